/* File: core/sep_guard_consts.svh */
// constants of the bulk program guard: opcodes, sizes, counts, timing
`ifndef SEP_GUARD_CONSTS_SVH
`define SEP_GUARD_CONSTS_SVH
`define SEP_OP_EXT      2'h0
`define SEP_OP_WRITE    2'h1
`define SEP_OP_READ     2'h2
`define SEP_OP_ERASE    2'h3
`define SEP_TOP_LOCK    2'h0
`define SEP_TOP_FILL    2'h1
`define SEP_TOP_CLEAR   2'h2
`define SEP_TOP_UNLOCK  2'h3
`define SEP_CNT_W       5
`define SEP_CNT_MAX     5'h1f
`define SEP_AW_X8       5'h09
`define SEP_AW_X16      5'h08
`define SEP_DW_X8       5'h08
`define SEP_DW_X16      5'h10
`define SEP_HDR_BITS    5'h03
`define SEP_BYTES       256
`define SEP_ERASED      8'hff
`define SEP_CLK_MHZ     50
`define SEP_T_PROG_US   10000
`define SEP_PROG_CYC    (`SEP_T_PROG_US * `SEP_CLK_MHZ)
`endif

/* File: core/sep_pkg.sv */
// types of the bulk program guard
package sep_pkg;
  typedef enum {ST_IDLE, ST_HUNT, ST_SHIFT, ST_BUSY} sep_state_t;
  typedef enum {CMD_READ, CMD_WRITE, CMD_ERASE, CMD_FILL, CMD_CLEAR, CMD_LOCK, CMD_UNLOCK} sep_cmd_t;
endpackage

/* File: core/sep_guard.sv */
// serial eeprom command slice: bulk erase/fill, ready/busy, pulse-count guard
`timescale 1ns/1ps
`include "sep_guard_consts.svh"
module sep_guard #(
  parameter int PROG_CYCLES = `SEP_PROG_CYC
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic cs_i,
  input  wire logic sck_i,
  input  wire logic din_i,
  input  wire logic org_i,
  output logic      dout_o,
  output logic      dout_oe_o
);
  import sep_pkg::*;

  localparam int TW = $clog2(PROG_CYCLES + 1);

  logic [1:0]           cs_s;
  logic [1:0]           sck_s;
  logic [1:0]           din_s;
  logic [1:0]           org_s;
  logic                 cs_prev_q;
  logic                 sck_prev_q;
  logic                 cs_rise;
  logic                 cs_fall;
  logic                 sck_rise;
  sep_state_t           state_q;
  logic [`SEP_CNT_W-1:0] cnt_q;
  logic [25:0]          sr_q;
  logic [1:0]           op_q;
  logic [1:0]           top_q;
  logic                 unlocked_q;
  logic                 armed_q;
  logic [TW-1:0]        timer_q;
  logic [7:0]           mem [`SEP_BYTES];
  logic                 dout_q;
  logic                 dout_oe_q;
  sep_cmd_t             cmd;
  logic                 prog_cmd;
  logic                 prog_go;
  logic                 start_seen;
  logic [7:0]           wr_addr;
  logic [15:0]          wr_data;

  // command kind from opcode and top address bits
  function automatic sep_cmd_t decode(input logic [1:0] op, input logic [1:0] top);
    sep_cmd_t c;
    c = CMD_READ;
    unique case (op)
      `SEP_OP_WRITE: c = CMD_WRITE;
      `SEP_OP_READ:  c = CMD_READ;
      `SEP_OP_ERASE: c = CMD_ERASE;
      `SEP_OP_EXT: begin
        unique case (top)
          `SEP_TOP_FILL:   c = CMD_FILL;
          `SEP_TOP_CLEAR:  c = CMD_CLEAR;
          `SEP_TOP_UNLOCK: c = CMD_UNLOCK;
          `SEP_TOP_LOCK:   c = CMD_LOCK;
        endcase
      end
    endcase
    return c;
  endfunction

  // exact pulse total a programming command must show
  function automatic logic [`SEP_CNT_W-1:0] req_count(input sep_cmd_t c, input logic x16);
    logic [`SEP_CNT_W-1:0] n;
    n = `SEP_HDR_BITS + (x16 ? `SEP_AW_X16 : `SEP_AW_X8);
    if (c == CMD_WRITE || c == CMD_FILL) begin
      n = n + (x16 ? `SEP_DW_X16 : `SEP_DW_X8);
    end
    return n;
  endfunction

  // two-stage synchronisers on every pin
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cs_s  <= 2'h0;
      sck_s <= 2'h0;
      din_s <= 2'h0;
      org_s <= 2'h0;
    end else begin
      cs_s  <= {cs_s[0], cs_i};
      sck_s <= {sck_s[0], sck_i};
      din_s <= {din_s[0], din_i};
      org_s <= {org_s[0], org_i};
    end
  end

  // edge history of the synchronised chip enable and shift clock
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cs_prev_q  <= 1'b0;
      sck_prev_q <= 1'b0;
    end else begin
      cs_prev_q  <= cs_s[1];
      sck_prev_q <= sck_s[1];
    end
  end

  assign cs_rise  = cs_s[1] & ~cs_prev_q;
  assign cs_fall  = ~cs_s[1] & cs_prev_q;
  assign sck_rise = sck_s[1] & ~sck_prev_q;

  // decode at chip enable fall; guard against wrong pulse totals
  always_comb begin
    cmd      = decode(op_q, top_q);
    prog_cmd = (cmd == CMD_WRITE) || (cmd == CMD_ERASE) || (cmd == CMD_FILL) || (cmd == CMD_CLEAR);
    prog_go  = (state_q == ST_SHIFT) && cs_fall && prog_cmd && unlocked_q
               && (cnt_q == req_count(cmd, org_s[1]));
    start_seen = (state_q == ST_HUNT) && sck_rise && din_s[1];
  end

  // address and data fields, valid when the total is exact
  always_comb begin
    if (org_s[1]) begin
      wr_data = sr_q[15:0];
      wr_addr = (cmd == CMD_ERASE) ? {1'b0, sr_q[6:0]} : {1'b0, sr_q[22:16]};
    end else begin
      wr_data = {8'h00, sr_q[7:0]};
      wr_addr = (cmd == CMD_ERASE) ? sr_q[7:0] : sr_q[15:8];
    end
  end

  // command sequencer; busy ignores every input edge
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (cs_rise) begin
            state_q <= ST_HUNT;
          end
        end
        ST_HUNT: begin
          if (!cs_s[1]) begin
            state_q <= ST_IDLE;
          end else if (start_seen) begin
            state_q <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (prog_go) begin
            state_q <= ST_BUSY;
          end else if (!cs_s[1]) begin
            state_q <= ST_IDLE;
          end
        end
        ST_BUSY: begin
          if (timer_q == '0) begin
            state_q <= cs_s[1] ? ST_HUNT : ST_IDLE;
          end
        end
      endcase
    end
  end

  // self-timed programming duration on the system clock
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      timer_q <= '0;
    end else if (prog_go) begin
      timer_q <= TW'(PROG_CYCLES - 1);
    end else if (state_q == ST_BUSY && timer_q != '0) begin
      timer_q <= timer_q - 1'b1;
    end
  end

  // pulse counter from start bit, cleared at chip enable rise, saturating
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_q <= '0;
    end else if (state_q == ST_BUSY) begin
      if (timer_q == '0) begin
        cnt_q <= '0;
      end
    end else if (cs_rise) begin
      cnt_q <= '0;
    end else if (start_seen) begin
      cnt_q <= `SEP_CNT_W'(1);
    end else if (state_q == ST_SHIFT && sck_rise && cnt_q != `SEP_CNT_MAX) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // shift register and opcode capture after the start bit
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sr_q  <= '0;
      op_q  <= 2'h0;
      top_q <= 2'h0;
    end else if (state_q == ST_SHIFT && sck_rise) begin
      sr_q <= {sr_q[24:0], din_s[1]};
      if (cnt_q == `SEP_CNT_W'(1)) begin
        op_q[1] <= din_s[1];
      end
      if (cnt_q == `SEP_CNT_W'(2)) begin
        op_q[0] <= din_s[1];
      end
      if (cnt_q == `SEP_CNT_W'(3)) begin
        top_q[1] <= din_s[1];
      end
      if (cnt_q == `SEP_CNT_W'(4)) begin
        top_q[0] <= din_s[1];
      end
    end
  end

  // unlock/lock, unchecked, once the address field is complete
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      unlocked_q <= 1'b0;
    end else if (state_q == ST_SHIFT && cs_fall
                 && cnt_q >= req_count(CMD_ERASE, org_s[1])) begin
      if (cmd == CMD_UNLOCK) begin
        unlocked_q <= 1'b1;
      end else if (cmd == CMD_LOCK) begin
        unlocked_q <= 1'b0;
      end
    end
  end

  // status shown from programming start until, once busy ends, a start bit or chip enable low
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      armed_q <= 1'b0;
    end else if (prog_go) begin
      armed_q <= 1'b1;
    end else if (state_q != ST_BUSY && (!cs_s[1] || start_seen)) begin
      armed_q <= 1'b0;
    end
  end

  // serial output: low busy, high ready, released otherwise
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dout_q    <= 1'b0;
      dout_oe_q <= 1'b0;
    end else begin
      dout_oe_q <= cs_s[1] & armed_q;
      dout_q    <= state_q != ST_BUSY;
    end
  end

  assign dout_o    = dout_q;
  assign dout_oe_o = dout_oe_q;

  // array: all ones at power-on, updated when a guarded command commits
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < `SEP_BYTES; i++) begin
        mem[i] <= `SEP_ERASED;
      end
    end else if (prog_go) begin
      unique case (cmd)
        CMD_CLEAR: begin
          for (int i = 0; i < `SEP_BYTES; i++) begin
            mem[i] <= `SEP_ERASED;
          end
        end
        CMD_FILL: begin
          for (int i = 0; i < `SEP_BYTES; i++) begin
            mem[i] <= (org_s[1] && i[0]) ? wr_data[15:8] : wr_data[7:0];
          end
        end
        CMD_ERASE: begin
          if (org_s[1]) begin
            mem[{wr_addr[6:0], 1'b0}] <= `SEP_ERASED;
            mem[{wr_addr[6:0], 1'b1}] <= `SEP_ERASED;
          end else begin
            mem[wr_addr] <= `SEP_ERASED;
          end
        end
        CMD_WRITE: begin
          if (org_s[1]) begin
            mem[{wr_addr[6:0], 1'b0}] <= wr_data[7:0];
            mem[{wr_addr[6:0], 1'b1}] <= wr_data[15:8];
          end else begin
            mem[wr_addr] <= wr_data[7:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // busy drives low with chip enable high
  chk_busy_low: assert property (@(posedge clk) disable iff (sys_rst)
    (state_q == ST_BUSY && cs_s[1]) |=> (dout_oe_q && !dout_q))
    else $error("busy not shown low");

  // ready shown high while armed and idle
  chk_ready_high: assert property (@(posedge clk) disable iff (sys_rst)
    (armed_q && cs_s[1] && state_q != ST_BUSY) |=> (dout_oe_q && dout_q))
    else $error("ready not shown high");

  // busy ignores clock edges
  chk_busy_ignore: assert property (@(posedge clk) disable iff (sys_rst)
    (state_q == ST_BUSY && timer_q != '0) |=> $stable(cnt_q) && $stable(sr_q))
    else $error("input taken while busy");

  // programming only on exact count
  chk_exact_count: assert property (@(posedge clk) disable iff (sys_rst)
    prog_go |-> (cnt_q == (org_s[1] ? req_count(cmd, 1'b1) : req_count(cmd, 1'b0))))
    else $error("programming with wrong pulse total");

  // wrong total returns to idle instead of busy
  chk_abandon: assert property (@(posedge clk) disable iff (sys_rst)
    (state_q == ST_SHIFT && cs_fall && cnt_q != req_count(cmd, org_s[1])) |=> (state_q == ST_IDLE))
    else $error("bad total not abandoned");

  // locked device never programs
  chk_locked: assert property (@(posedge clk) disable iff (sys_rst)
    (state_q == ST_SHIFT && cs_fall && !unlocked_q) |=> (state_q != ST_BUSY))
    else $error("programming while locked");

  // counter saturates at its top
  chk_cnt_sat: assert property (@(posedge clk) disable iff (sys_rst)
    (state_q == ST_SHIFT && cnt_q == `SEP_CNT_MAX && !cs_rise) |=> (cnt_q == `SEP_CNT_MAX || state_q != ST_SHIFT))
    else $error("pulse counter wrapped");

  // start bit enters shift with count one
  chk_start_bit: assert property (@(posedge clk) disable iff (sys_rst)
    start_seen && cs_s[1] |=> (state_q == ST_SHIFT && cnt_q == `SEP_CNT_W'(1)))
    else $error("start bit not decoded");

  // busy timer loads the full duration
  chk_busy_len: assert property (@(posedge clk) disable iff (sys_rst)
    prog_go |=> (state_q == ST_BUSY && timer_q == TW'(PROG_CYCLES - 1)))
    else $error("busy duration wrong");

  // clear-all leaves ones at both ends of the array
  chk_clear_ones: assert property (@(posedge clk) disable iff (sys_rst)
    (prog_go && cmd == CMD_CLEAR) |=> (mem[0] == `SEP_ERASED && mem[`SEP_BYTES-1] == `SEP_ERASED))
    else $error("clear-all left zeros");

  // fill-all copies data to the first location
  chk_fill_data: assert property (@(posedge clk) disable iff (sys_rst)
    (prog_go && cmd == CMD_FILL) |=> (mem[0] == $past(wr_data[7:0])))
    else $error("fill-all data wrong");

endmodule // sep_guard

/* File: verification/sep_master_model.sv */
// master model: drives chip enable, shift clock and serial data of the slice
`timescale 1ns/1ps
module sep_master_model (
  input  wire logic clk,
  output logic      cs,
  output logic      sck,
  output logic      din
);
  localparam int HALF = 4; // 4 clk high, 4 clk low: 160 ns link period

  // idle link: chip enable low, shift clock parked low
  initial begin
    cs = 1'b0;
    sck = 1'b0;
    din = 1'b0;
  end

  // wait some clk edges, then move just after the last one
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // chip enable change; the released data line flips so no stale level lingers
  task automatic set_cs(input logic v);
    tick(1);
    cs = v;
    din = ~din;
    tick(HALF);
  endtask

  // one shift pulse: data set while low, held through the rising edge
  task automatic pulse(input logic b);
    din = b;
    tick(HALF);
    sck = 1'b1;
    tick(HALF);
    sck = 1'b0;
  endtask

  // argument-free shorthands so the bench never hard-wires a link level
  task automatic select();
    set_cs(1'b1);
  endtask

  task automatic deselect();
    set_cs(1'b0);
  endtask

  task automatic zero();
    pulse(1'b0);
  endtask

  task automatic one();
    pulse(1'b1);
  endtask

  task automatic settle();
    tick(HALF);
  endtask

  // separate in and out lines here, so the last address bit never meets the output
endmodule // sep_master_model

/* File: verification/test_sep_guard.sv */
// self-checking bench for the bulk program guard
`timescale 1ns/1ps
module test_sep_guard;
  localparam int PROG = 400;
  logic        clk;
  logic        sys_rst;
  logic        org_i;
  logic        cs;
  logic        sck;
  logic        din;
  logic        dout_o;
  logic        dout_oe_o;
  logic [31:0] rng;
  int          err_total;
  int          n_checks;
  int          unlocked;
  int          mdl [256];

  // 50 MHz system clock
  initial clk = 1'b0;
  always #10 clk = ~clk;

  // block under test, short programming time
  sep_guard #(.PROG_CYCLES(PROG)) sep_guard_inst (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .cs_i      (cs),
    .sck_i     (sck),
    .din_i     (din),
    .org_i     (org_i),
    .dout_o    (dout_o),
    .dout_oe_o (dout_oe_o)
  );

  // far-side master
  sep_master_model sep_master_model_inst (
    .clk (clk),
    .cs  (cs),
    .sck (sck),
    .din (din)
  );

  // xorshift source for address and data fields
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction

  // compare one status pair or one array byte
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // verdict and end of run
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // one frame: build bits, predict with the model, send, watch status
  task automatic do_cmd(input int op, input int top, input int extra, input int lead, input bit sb);
    int          aw;
    int          dw;
    int          n;
    logic [63:0] bits;
    logic        ex;
    int          wa;
    aw = org_i ? 8 : 9;
    dw = (op == 1 || (op == 0 && top == 1)) ? (org_i ? 16 : 8) : 0;
    rng = xs(rng);
    bits = 64'(4 + op);
    // dummy low address bits on bulk commands
    bits = (bits << aw) | 64'(op == 0 ? (top << (aw - 2)) | (rng[6:0] >> (9 - aw)) : rng[8:0] >> (9 - aw));
    bits = (bits << dw) | 64'(rng[31:16] >> (16 - dw));
    n = 3 + aw + dw;
    if (extra < 0) begin
      bits = bits >> -extra;
    end else begin
      bits = bits << extra;
    end
    n = n + extra;
    ex = unlocked != 0 && op != 2 && !(op == 0 && (top == 0 || top == 3)) && n == 3 + aw + dw;
    if (op == 0 && top == 3 && n >= 3 + aw) unlocked = 1;
    if (op == 0 && top == 0 && n >= 3 + aw) unlocked = 0;
    // expected array after the frame; word address picks an even/odd byte pair
    if (ex) begin
      wa = org_i ? int'({rng[7:1], 1'b0}) : int'(rng[7:0]);
      for (int i = 0; i < 256; i++) begin
        if (op == 0 && top == 2) mdl[i] = 32'h0000_00ff;
        if (op == 0 && top == 1) mdl[i] = (org_i && i % 2 == 0) ? int'(rng[23:16]) : int'(rng[31:24]);
      end
      if (op == 1 || op == 3) begin
        mdl[wa] = op == 3 ? 32'h0000_00ff : org_i ? int'(rng[23:16]) : int'(rng[31:24]);
        if (org_i) mdl[wa + 1] = op == 3 ? 32'h0000_00ff : int'(rng[31:24]);
      end
    end
    sep_master_model_inst.select();
    repeat (lead) sep_master_model_inst.zero();
    for (int i = n - 1; i >= 0; i--) sep_master_model_inst.pulse(bits[i]);
    sep_master_model_inst.deselect();
    sep_master_model_inst.select();
    sep_master_model_inst.settle();
    chk({dout_oe_o, dout_oe_o & dout_o}, ex ? 2'h2 : 2'h0);
    if (ex) begin
      // a lock frame sent while busy must leave no trace
      for (int i = 0; i < 13; i++) sep_master_model_inst.pulse(i == 0);
      sep_master_model_inst.deselect();
      sep_master_model_inst.select();
      sep_master_model_inst.settle();
      chk({dout_oe_o, dout_oe_o & dout_o}, 2'h2);
      sep_master_model_inst.tick(PROG);
      chk({dout_oe_o, dout_oe_o & dout_o}, 2'h3);
      if (sb) begin
        sep_master_model_inst.zero();
        sep_master_model_inst.zero();
        sep_master_model_inst.settle();
        chk({dout_oe_o, dout_oe_o & dout_o}, 2'h3);
        sep_master_model_inst.one();
        sep_master_model_inst.settle();
        chk({dout_oe_o, 1'b0}, 2'h0);
      end
    end
    sep_master_model_inst.deselect();
    sep_master_model_inst.settle();
    chk({dout_oe_o, 1'b0}, 2'h0);
    for (int i = 0; i < 256; i++) chk(sep_guard_inst.mem[i], 8'(mdl[i]));
    $display("test op %0d top %0d pulses %0d done", op, top, n);
  endtask

  // main sequence
  initial begin
    sys_rst = 1'b1;
    org_i = 1'b0;
    rng = 32'h8e71_2f2e;
    err_total = 0;
    n_checks = 0;
    unlocked = 0;
    for (int i = 0; i < 256; i++) mdl[i] = 32'h0000_00ff;
    repeat (6) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    sep_master_model_inst.settle();
    do_cmd(0, 1, 0, 0, 0);  // fill while locked after power-on
    do_cmd(0, 3, 0, 2, 0);  // unlock behind leading zeros
    do_cmd(0, 1, 0, 0, 1);  // fill, 20 pulses
    do_cmd(0, 1, -1, 0, 0); // 19 pulses
    do_cmd(0, 1, 1, 0, 0);  // 21 pulses
    do_cmd(0, 2, 0, 3, 0);  // clear-all
    do_cmd(1, 0, 0, 0, 0);  // single write
    do_cmd(3, 0, 0, 0, 0);  // single erase
    do_cmd(2, 0, 0, 0, 0);  // read gives no status
    do_cmd(1, 0, 32, 0, 0); // 52 pulses, counter must not wrap
    sep_master_model_inst.settle();
    org_i = 1'b1;
    do_cmd(1, 0, 0, 0, 1);  // word write, 27 pulses
    do_cmd(1, 0, -1, 0, 0); // 26 pulses
    do_cmd(1, 0, 32, 0, 0); // 59 pulses
    do_cmd(0, 1, 0, 0, 0);  // word fill
    do_cmd(0, 2, 0, 0, 0);  // word clear-all
    do_cmd(0, 0, 0, 0, 0);  // lock
    do_cmd(1, 0, 0, 0, 0);  // word write refused when locked
    complete_run();
  end

  // watchdog well past the expected run length
  initial begin
    repeat (40000) @(posedge clk);
    err_total++;
    complete_run();
  end
endmodule // test_sep_guard
